/* src/qpwm.sv */
// Local design decisions: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "qpwm_defines.svh"

module qpwm (
	// clock, reset, freeze
	input wire logic clock,
	input wire logic nrst,
	input wire logic ce,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// shared port pins
	input wire qpwm_pkg::qpwm_pins_t pin_in,
	output qpwm_pkg::qpwm_pins_t pin_out,
	output qpwm_pkg::qpwm_pins_t pin_oe
);
	import qpwm_pkg::*;
	// one bus clock drives everything; clocks A, B, S0 and S1
	// are single-cycle enables, not real clocks, so nothing crosses domains

	// 17-bit result: direction bit over next count
	// shared by 8-bit channels (zero-extended) and the 16-bit pairs
	// trade-off: one wide step function instead of two narrow copies
	function automatic logic [16:0] step(input logic [15:0] c, input logic [15:0] p,
		input logic down, input logic center);
		logic [16:0] r;
		// default: count up, direction up
		r = {1'b0, c + 16'h0001};
		if (!center) begin
			// left: restart at zero on period match
			if (c >= p) begin
				r = {1'b0, 16'h0000};
			end
		end else if (!down) begin
			// center: turn round at period
			if (c >= p) begin
				r = {1'b1, (c == 16'h0000) ? c : c - 16'h0001};
			end
		end else if (c == 16'h0000) begin
			// center: bottom ends the period
			r = {1'b0, (p == 16'h0000) ? c : c + 16'h0001};
		end else begin
			r = {1'b1, c - 16'h0001};
		end
		return r;
	endfunction

	// control registers
	// at most byte-wide, carried in bits 7:0 of the bus word
	logic [7:0] clkpair; // pairing and prescale
	logic [7:0] selpol; // clock selects and polarities
	logic [3:0] enable; // channel enables
	logic center; // center-aligned mode
	logic [7:0] scale [2]; // scale values lower/upper
	logic [3:0] port_dir; // port direction, never altered by enables
	logic [3:0] port_data; // port output data

	// channel state
	// buffers take every write; latches feed the compare
	logic [7:0] cnt [4]; // live counters
	qpwm_dir_t dir [4]; // count direction
	logic [7:0] per_buf [4]; // period as written
	logic [7:0] dty_buf [4]; // duty as written
	logic [7:0] per_act [4]; // period in use
	logic [7:0] dty_act [4]; // duty in use
	logic [3:0] wave; // registered waveform

	// clock generation
	// masks turn the 3-bit prescale fields into tick conditions
	// an S tick needs two reload passes of its scaler
	logic [6:0] pres; // free-running prescaler
	logic [7:0] scnt [2]; // scale down-counters
	logic [1:0] shalf; // final halving stage
	logic [1:0] ab_tick; // clock A / clock B enables
	logic [1:0] s_tick; // S0 / S1 enables
	logic [6:0] mask [2]; // prescaler match masks

	// pin input synchroniser
	// stage 1 may go metastable, so only stage 2 reads it
	logic [3:0] pin_s1;
	logic [3:0] pin_s2;
	logic [3:0] pin_s3;
	logic [3:0] pin_q; // accepted pin level
	logic [3:0] agree;

	// bus decode
	// only byte lane 0 carries data; other lanes read zero
	// unmapped indexes are still acked, writes to them dropped
	logic ack;
	logic [31:0] rdat;
	wire req = wb_cyc_i & wb_stb_i;
	wire [5:0] idx = wb_adr_i[7:2];
	// write lands on the edge the master sees ack
	wire wr = req & wb_we_i & ack & wb_sel_i[0];
	wire [7:0] wdat = wb_dat_i[7:0];
	wire [3:0] grp = idx[5:2];
	wire [1:0] sub = idx[1:0];
	wire wr_clkpair = wr & (idx == `QPWM_IDX_CLKPAIR);
	wire wr_selpol = wr & (idx == `QPWM_IDX_SELPOL);
	wire wr_enable = wr & (idx == `QPWM_IDX_ENABLE);
	wire wr_control = wr & (idx == `QPWM_IDX_CONTROL);
	wire wr_scale_lo = wr & (idx == `QPWM_IDX_SCALE_LO);
	wire wr_scale_up = wr & (idx == `QPWM_IDX_SCALE_UP);
	wire wr_port_dir = wr & (idx == `QPWM_IDX_PORT_DIR);
	wire wr_port_data = wr & (idx == `QPWM_IDX_PORT_DATA);
	wire [1:0] wr_scale = {wr_scale_up, wr_scale_lo};

	// named fields
	// pairing bits sit on top, clock fields below
	// RQ22 field layout
	wire [1:0] pair = {clkpair[`QPWM_PAIR_UP_BIT], clkpair[`QPWM_PAIR_LO_BIT]};
	wire [2:0] cka = clkpair[`QPWM_CKA_MSB:`QPWM_CKA_LSB];
	wire [2:0] ckb = clkpair[`QPWM_CKB_MSB:`QPWM_CKB_LSB];
	wire [3:0] sel = selpol[`QPWM_SEL_MSB:`QPWM_SEL_LSB];
	wire [3:0] pol = selpol[`QPWM_POL_MSB:`QPWM_POL_LSB];

	// read selection; unmapped reads zero
	// port data reads the data register where port_dir is set, the pin elsewhere
	// RQ8 counters readable
	wire [7:0] rd_byte =
		(idx == `QPWM_IDX_CLKPAIR) ? clkpair :
		(idx == `QPWM_IDX_SELPOL) ? selpol :
		(idx == `QPWM_IDX_ENABLE) ? {4'h0, enable} :
		(idx == `QPWM_IDX_CONTROL) ? {7'h00, center} :
		(idx == `QPWM_IDX_SCALE_LO) ? scale[0] :
		(idx == `QPWM_IDX_SCALE_UP) ? scale[1] :
		(idx == `QPWM_IDX_PORT_DIR) ? {4'h0, port_dir} :
		(idx == `QPWM_IDX_PORT_DATA) ? {4'h0, (port_data & port_dir) | (pin_q & ~port_dir)} :
		(grp == `QPWM_GRP_CNT) ? cnt[sub] :
		(grp == `QPWM_GRP_PER) ? per_buf[sub] :
		(grp == `QPWM_GRP_DTY) ? dty_buf[sub] :
		`QPWM_RST_BYTE;

	assign wb_ack_o = ack;
	assign wb_dat_o = rdat;

	// ack one cycle after request, dropped the cycle after
	// read data is registered together with the ack
	// limitation: ack freezes with ce, so keep ce high across
	// a bus cycle or a write seen as acked may not land
	always_ff @(posedge clock) begin
		if (!nrst) begin
			ack <= 1'b0;
			rdat <= 32'h00000000;
		end else if (ce) begin
			ack <= req & ~ack;
			rdat <= {24'h000000, rd_byte};
		end
	end

	// control registers
	// RQ18 writable anytime
	always_ff @(posedge clock) begin
		if (!nrst) begin
			// RQ23 zero reset
			clkpair <= `QPWM_RST_BYTE;
			selpol <= `QPWM_RST_BYTE;
			enable <= `QPWM_RST_NIB;
			center <= 1'b0;
			port_dir <= `QPWM_RST_NIB;
			port_data <= `QPWM_RST_NIB;
		end else if (ce) begin
			if (wr_clkpair) begin
				clkpair <= wdat;
			end
			if (wr_selpol) begin
				selpol <= wdat;
			end
			// enables reach the pins one cycle after the write lands
			if (wr_enable) begin
				enable <= wdat[3:0];
			end
			// alignment should only change with channels off
			if (wr_control) begin
				// RQ3 alignment select
				center <= wdat[`QPWM_CENTER_BIT];
			end
			// direction stays as written; enables override it at the pin only
			if (wr_port_dir) begin
				port_dir <= wdat[3:0];
			end
			if (wr_port_data) begin
				port_data <= wdat[3:0];
			end
		end
	end

	// prescaler runs on the E clock
	// free-running even with all channels off: costs some power,
	// but keeps clocks A and B in a fixed phase
	always_ff @(posedge clock) begin
		if (!nrst) begin
			pres <= `QPWM_RST_PRES;
		end else if (ce) begin
			pres <= pres + 7'h01;
		end
	end

	// RQ13 divide by 2^n: tick when low n bits are all ones
	// n = 0 gives an empty mask, so the clock ticks every cycle
	assign mask[0] = 7'((8'h01 << cka) - 8'h01);
	assign mask[1] = 7'((8'h01 << ckb) - 8'h01);

	// pin synchroniser; a level counts once stages 2 and 3 agree
	// a one-cycle mismatch between stages 2 and 3 is ignored
	assign agree = ~(pin_s2 ^ pin_s3);
	always_ff @(posedge clock) begin
		if (!nrst) begin
			pin_s1 <= `QPWM_RST_NIB;
			pin_s2 <= `QPWM_RST_NIB;
			pin_s3 <= `QPWM_RST_NIB;
			pin_q <= `QPWM_RST_NIB;
		end else if (ce) begin
			pin_s1 <= pin_in;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			pin_q <= (pin_q & ~agree) | (pin_s2 & agree);
		end
	end

	// per pair: clock A/B, scaled S0/S1, and the 16-bit counter path
	// 16-bit results, used only while a pair is joined
	logic [16:0] pair_nxt [2];
	logic [1:0] pair_roll;
	logic [1:0] pair_wave;
	// pair 0 runs from clock A, pair 1 from clock B
	genvar p;
	generate
		for (p = 0; p < 2; p++) begin : g_pair
			localparam int H = 2 * p;
			// high byte from the even channel, low byte from the odd one
			wire [15:0] pc = {cnt[H], cnt[H + 1]};
			wire [15:0] pp = {per_act[H], per_act[H + 1]};
			wire [15:0] pd = {dty_act[H], dty_act[H + 1]};
			wire pdown = (dir[H] == QPWM_DOWN);

			// RQ12 clock A for lower pair, B for upper
			assign ab_tick[p] = ((pres & mask[p]) == mask[p]);
			// RQ19 halve after every second reload
			assign s_tick[p] = ab_tick[p] & (scnt[p] == 8'h00) & shalf[p];

			// scaler: write reloads, zero reloads
			// a scale write also restarts the halving so S starts clean
			always_ff @(posedge clock) begin
				if (!nrst) begin
					scnt[p] <= `QPWM_RST_BYTE;
					scale[p] <= `QPWM_RST_BYTE;
					shalf[p] <= 1'b0;
				end else if (ce) begin
					if (wr_scale[p]) begin
						scale[p] <= wdat;
						scnt[p] <= wdat;
						shalf[p] <= 1'b0;
					end else if (ab_tick[p]) begin
						// RQ19 divide by scale plus one
						if (scnt[p] == 8'h00) begin
							scnt[p] <= scale[p];
							shalf[p] <= ~shalf[p];
						end else begin
							scnt[p] <= scnt[p] - 8'h01;
						end
					end
				end
			end

			// RQ1 concatenated 16-bit counter
			assign pair_nxt[p] = step(pc, pp, pdown, center);
			assign pair_roll[p] = center ? (pdown & (pc == 16'h0000)) : (pc >= pp);
			// RQ17 polarity sets the starting level
			assign pair_wave[p] = pol[H] ^ ((pd < pp) & (center ? (pc >= pd) : (pc > pd)));
		end
	endgenerate

	// per channel
	// each pair of channels shares one clock A/B and one scaled clock
	logic [3:0] drive; // pwm owns the pin
	logic [3:0] tick_ch; // selected channel clock
	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_ch
			localparam int P = i / 2;
			localparam int H = 2 * P;
			localparam bit IS_HIGH = (i == H);
			// RQ10 RQ11 pairing takes high-byte pin, low-byte clock
			// the low byte of a pair keeps its own registers
			// but follows the pair's enable and clock
			wire cat = pair[P];
			wire en_eff = cat ? enable[H] : enable[i];
			// RQ14 RQ15 select A/B or S0/S1
			// RQ16 plain mux, a switch may clip one pulse
			assign tick_ch[i] = sel[i] ? s_tick[P] : ab_tick[P];
			wire tick_eff = cat ? tick_ch[H + 1] : tick_ch[i];
			wire down = (dir[i] == QPWM_DOWN);
			// RQ2 own counter, period and duty
			wire [16:0] one_nxt = step({8'h00, cnt[i]}, {8'h00, per_act[i]}, down, center);
			// rollover ends the period in either alignment
			wire one_roll = center ? (down & (cnt[i] == 8'h00)) : (cnt[i] >= per_act[i]);
			// RQ4 duty at or above period holds one level
			// RQ20 same polarity rule on every channel
			wire one_wave = pol[i] ^ ((dty_act[i] < per_act[i]) &
				(center ? (cnt[i] >= dty_act[i]) : (cnt[i] > dty_act[i])));
			wire [7:0] nxt_cnt = cat ? (IS_HIGH ? pair_nxt[P][15:8] : pair_nxt[P][7:0]) :
				one_nxt[7:0];
			wire nxt_down = cat ? pair_nxt[P][16] : one_nxt[16];
			wire roll_eff = cat ? pair_roll[P] : one_roll;
			// counter write decode for both halves of the pair
			wire wr_cnt_h = wr & (idx == {`QPWM_GRP_CNT, 2'(H)});
			wire wr_cnt_l = wr & (idx == {`QPWM_GRP_CNT, 2'(H + 1)});
			wire wr_cnt_i = wr & (idx == {`QPWM_GRP_CNT, 2'(i)});
			// either half clears the whole paired counter
			wire cnt_clr = cat ? (wr_cnt_h | wr_cnt_l) : wr_cnt_i;
			wire wr_per = wr & (idx == {`QPWM_GRP_PER, 2'(i)});
			wire wr_dty = wr & (idx == {`QPWM_GRP_DTY, 2'(i)});
			// bytes that the latches would take this cycle
			wire [7:0] next_per = wr_per ? wdat : per_buf[i];
			wire [7:0] next_dty = wr_dty ? wdat : dty_buf[i];
			// RQ5 latch only on rollover, on a counter write or while disabled
			wire load = ~en_eff | cnt_clr | (tick_eff & roll_eff);

			// RQ9 enabled channel drives its pin; paired low pin stays port
			assign drive[i] = en_eff & (IS_HIGH | ~cat);

			always_ff @(posedge clock) begin
				if (!nrst) begin
					cnt[i] <= `QPWM_RST_BYTE;
					dir[i] <= QPWM_UP;
					per_buf[i] <= `QPWM_RST_BYTE;
					dty_buf[i] <= `QPWM_RST_BYTE;
					per_act[i] <= `QPWM_RST_BYTE;
					dty_act[i] <= `QPWM_RST_BYTE;
				end else if (ce) begin
					// buffers always take the write; counter holds while off, except that a counter write still clears it
					per_buf[i] <= next_per;
					dty_buf[i] <= next_dty;
					// RQ7 counter write restarts the period
					if (cnt_clr) begin
						cnt[i] <= `QPWM_RST_BYTE;
						dir[i] <= QPWM_UP;
					end else if (en_eff & tick_eff) begin
						cnt[i] <= nxt_cnt;
						dir[i] <= nxt_down ? QPWM_DOWN : QPWM_UP;
					end
					// RQ6 disabled: write passes straight to the latch
					if (load) begin
						per_act[i] <= next_per;
						dty_act[i] <= next_dty;
					end
				end
			end

			// waveform and pin drivers from flops
			// two flop stages: counter to wave, wave to pin
			always_ff @(posedge clock) begin
				if (!nrst) begin
					wave[i] <= 1'b0;
					pin_out[i] <= 1'b0;
					pin_oe[i] <= 1'b0;
				end else if (ce) begin
					// wave lags the counter by one cycle
					wave[i] <= cat ? pair_wave[P] : one_wave;
					// a released pin shows the port data register
					pin_out[i] <= drive[i] ? wave[i] : port_data[i];
					// RQ21 enable forces output, direction bit untouched
					pin_oe[i] <= drive[i] | port_dir[i];
				end
			end
		end
	endgenerate

endmodule

/* src/qpwm_defines.svh */
// Behaviour
// RQ1: four 8-bit channels, or paired 16-bit channels
// RQ2: each channel has counter, period, duty
// RQ3: left-aligned or center-aligned mode by software
// RQ4: duty spans fully inactive to fully active; left-aligned duty 0 still holds the starting level at count 0
// RQ5: enabled channel buffers writes until rollover/disable
// RQ6: disabled channel writes buffer and latch together
// RQ7: counter write clears counter, latches buffers
// RQ8: counters are readable by software
// RQ9: enabled output overrides port; others stay port
// RQ10: upper pair: ch2 high, pin 2, ch3 clock
// RQ11: lower pair: ch0 high, pin 0, ch1 clock
// RQ12: clock A feeds ch0/1, clock B ch2/3
// RQ13: prescale field n divides E by 2^n
// RQ14: ch2/3 select: clear clock B, set S1
// RQ15: ch0/1 select: clear clock A, set S0
// RQ16: clock select change may glitch one pulse
// RQ17: polarity clear starts low, set starts high
// RQ18: both control registers read/write anytime
// RQ19: S = clock / (scale+1) / 2
// RQ20: channel 0 polarity behaves like others
// RQ21: enable forces pin output, direction bit kept
// RQ22: control register bit layout as specified
// RQ23: both control registers reset to zero
`ifndef QPWM_DEFINES_SVH
`define QPWM_DEFINES_SVH

// word indexes (byte address = index * 4)
`define QPWM_IDX_CLKPAIR 6'h00
`define QPWM_IDX_SELPOL 6'h01
`define QPWM_IDX_ENABLE 6'h02
`define QPWM_IDX_CONTROL 6'h03
`define QPWM_IDX_SCALE_LO 6'h04
`define QPWM_IDX_SCALE_UP 6'h05
`define QPWM_IDX_PORT_DIR 6'h06
`define QPWM_IDX_PORT_DATA 6'h07
// per-channel groups: index = {group, channel}
`define QPWM_GRP_CNT 4'h2
`define QPWM_GRP_PER 4'h3
`define QPWM_GRP_DTY 4'h4

// field positions
`define QPWM_PAIR_UP_BIT 7
`define QPWM_PAIR_LO_BIT 6
`define QPWM_CKA_MSB 5
`define QPWM_CKA_LSB 3
`define QPWM_CKB_MSB 2
`define QPWM_CKB_LSB 0
`define QPWM_SEL_MSB 7
`define QPWM_SEL_LSB 4
`define QPWM_POL_MSB 3
`define QPWM_POL_LSB 0
`define QPWM_CENTER_BIT 0

// reset values
`define QPWM_RST_BYTE 8'h00
`define QPWM_RST_NIB 4'h0
`define QPWM_RST_PRES 7'h00

`endif

/* src/qpwm_pkg.sv */
package qpwm_pkg;
	// one bit per port pin
	typedef logic [3:0] qpwm_pins_t;
	// counter direction in center-aligned mode
	typedef enum logic {QPWM_UP, QPWM_DOWN} qpwm_dir_t;
endpackage

/* testbench/qpwm_properties.sv */
`timescale 1ns/1ps
module qpwm_properties (
	// clock, reset, freeze
	input wire logic clock,
	input wire logic nrst,
	input wire logic ce,
	// bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// pins
	input wire qpwm_pkg::qpwm_pins_t pin_out,
	input wire qpwm_pkg::qpwm_pins_t pin_oe
);
	import qpwm_pkg::*;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);
	// last value written to the pairing register
	logic [7:0] shadow;
	always_ff @(posedge clock) begin
		if (!nrst)
			shadow <= 8'h00;
		else if (ce && wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i[7:2] == 6'h00)
			shadow <= wb_dat_i[7:0];
	end
	// a request not yet answered
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
	endsequence
	sequence s_rd_miss;
		s_req ##0 (!wb_we_i && wb_adr_i[7:2] > 6'h13);
	endsequence
	sequence s_rd_pair;
		s_req ##0 (!wb_we_i && wb_adr_i[7:2] == 6'h00);
	endsequence
	property p_ack_next;
		s_req |=> wb_ack_o;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("request not answered");
	property p_ack_pulse;
		wb_ack_o && ce |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
	property p_ack_cause;
		$rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	property p_dat_hi;
		wb_ack_o |-> wb_dat_o[31:8] == 24'h000000;
	endproperty
	a_dat_hi: assert property (p_dat_hi) else $error("read data upper bits set");
	property p_miss_zero;
		s_rd_miss |=> wb_dat_o == 32'h00000000;
	endproperty
	a_miss_zero: assert property (p_miss_zero) else $error("unmapped read not zero");
	property p_pair_read;
		s_rd_pair |=> wb_dat_o[7:0] == shadow;
	endproperty
	a_pair_read: assert property (p_pair_read) else $error("pairing readback wrong");
	property p_reset_pins;
		$rose(nrst) |-> pin_oe == 4'h0 && pin_out == 4'h0 && !wb_ack_o;
	endproperty
	a_reset_pins: assert property (p_reset_pins) else $error("pins not idle at reset");
	property p_oe_cause;
		$changed(pin_oe) |-> $past(wb_ack_o) || $past(wb_ack_o, 2) || $past(wb_ack_o, 3);
	endproperty
	a_oe_cause: assert property (p_oe_cause) else $error("pin enable moved alone");
	property p_freeze;
		!ce |=> $stable(pin_out) && $stable(pin_oe) && $stable(wb_ack_o);
	endproperty
	a_freeze: assert property (p_freeze) else $error("outputs moved while frozen");
endmodule
bind qpwm qpwm_properties chk_u (.clock, .nrst, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pin_out, .pin_oe);

/* testbench/qpwm_pin_load.sv */
`timescale 1ns/1ps
// pull-ups on every pin plus an outside driver the bench can switch on
module qpwm_pin_load (
	// from the block
	input wire qpwm_pkg::qpwm_pins_t pin_out,
	input wire qpwm_pkg::qpwm_pins_t pin_oe,
	// outside driver
	input wire qpwm_pkg::qpwm_pins_t ext_en,
	input wire qpwm_pkg::qpwm_pins_t ext_val,
	output qpwm_pkg::qpwm_pins_t pin_in
);
	import qpwm_pkg::*;
	// block drive wins, then the outside driver; pins nobody drives float up
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ((ext_en & ext_val) | ~ext_en));
endmodule

/* testbench/qpwm_tb_top.sv */
`timescale 1ns/1ps
`include "qpwm_defines.svh"
module qpwm_tb_top;
	import qpwm_pkg::*;
	logic clock = 1'b0, nrst = 1'b0, ce = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0, wb_ack_o;
	logic [7:0] wb_adr_i = 8'h00, q;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
	qpwm_pins_t pin_in, pin_out, pin_oe, ext_en = 4'h0, ext_val = 4'h0;
	int num_errors = 0, checked = 0;
	qpwm dut_u (.clock, .nrst, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .pin_in, .pin_out, .pin_oe);
	qpwm_pin_load load_u (.pin_out, .pin_oe, .ext_en, .ext_val, .pin_in);
	initial begin
		forever #5 clock = ~clock;
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// one classic cycle; waits for ack, takes data at that edge
	task automatic xfer(input logic [5:0] idx, input logic w, input logic [7:0] d);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= {idx, 2'b00};
		wb_dat_i <= {24'h0, d};
		wb_sel_i <= 4'h1;
		do begin
			@(posedge clock);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		check("ack", wb_ack_o, 1'b1);
		q = wb_dat_o[7:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clock);
	endtask
	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		xfer(idx, 1'b1, d);
	endtask
	// cycles between the third and fourth rising edges of one pin, bounded;
	// the first two may be cut short by an enable or a clock change
	task automatic expect_period(input string what, input int i, input int exp);
		logic p;
		int n, k, t;
		t = 0;
		k = 0;
		n = 0;
		p = pin_out[i];
		while (k < 4 && n < 4000) begin
			@(posedge clock);
			n++;
			if (k == 3)
				t++;
			if (pin_out[i] === 1'b1 && p === 1'b0)
				k++;
			p = pin_out[i];
		end
		check(what, t, exp);
	endtask
	task automatic t_regs();
		xfer(`QPWM_IDX_CLKPAIR, 1'b0, 8'h00);
		check("clkpair reset", q, 8'h00);
		xfer(`QPWM_IDX_SELPOL, 1'b0, 8'h00);
		check("selpol reset", q, 8'h00);
		wr(`QPWM_IDX_CLKPAIR, 8'hA5);
		wr(`QPWM_IDX_SELPOL, 8'h5A);
		xfer(`QPWM_IDX_CLKPAIR, 1'b0, 8'h00);
		check("clkpair rw", q, 8'hA5);
		xfer(`QPWM_IDX_SELPOL, 1'b0, 8'h00);
		check("selpol rw", q, 8'h5A);
		xfer(6'h3F, 1'b0, 8'h00);
		check("unmapped", q, 8'h00);
		wr(`QPWM_IDX_CLKPAIR, 8'h00);
		wr(`QPWM_IDX_SELPOL, 8'h00);
	endtask
	task automatic t_pins();
		ext_en <= 4'hF;
		ext_val <= 4'h6;
		repeat (4) @(posedge clock);
		xfer(`QPWM_IDX_PORT_DATA, 1'b0, 8'h00);
		check("port input", q[3:0], 4'h6);
		wr(`QPWM_IDX_ENABLE, 8'h02);
		repeat (3) @(posedge clock);
		check("enabled pin", pin_oe, 4'h2);
		xfer(`QPWM_IDX_PORT_DIR, 1'b0, 8'h00);
		check("dir kept", q, 8'h00);
		ce <= 1'b0;
		repeat (3) @(posedge clock);
		ce <= 1'b1;
		wr(`QPWM_IDX_ENABLE, 8'h00);
		repeat (3) @(posedge clock);
		check("released pin", pin_oe, 4'h0);
	endtask
	task automatic t_polarity();
		for (int c = 0; c < 4; c++) begin
			wr({`QPWM_GRP_PER, c[1:0]}, 8'h10);
			wr({`QPWM_GRP_DTY, c[1:0]}, 8'hFF);
		end
		wr(`QPWM_IDX_SELPOL, 8'h0A);
		wr(`QPWM_IDX_ENABLE, 8'h0F);
		repeat (4) @(posedge clock);
		check("polarity A", pin_out, 4'hA);
		wr(`QPWM_IDX_SELPOL, 8'h05);
		repeat (4) @(posedge clock);
		check("polarity 5", pin_out, 4'h5);
		wr(`QPWM_IDX_ENABLE, 8'h00);
		wr(`QPWM_IDX_SELPOL, 8'h00);
	endtask
	task automatic t_clocks();
		for (int c = 0; c < 4; c++) begin
			wr({`QPWM_GRP_PER, c[1:0]}, 8'h03);
			wr({`QPWM_GRP_DTY, c[1:0]}, 8'h01);
		end
		wr(`QPWM_IDX_ENABLE, 8'h05);
		for (int n = 0; n < 8; n++) begin
			wr(`QPWM_IDX_CLKPAIR, {2'b00, n[2:0], n[2:0]});
			expect_period("clock a", 0, 4 << n);
			expect_period("clock b", 2, 4 << n);
		end
		wr(`QPWM_IDX_CLKPAIR, 8'h00);
		wr(`QPWM_IDX_ENABLE, 8'h00);
		wr(`QPWM_IDX_CONTROL, 8'h01);
		wr(`QPWM_IDX_ENABLE, 8'h01);
		expect_period("center", 0, 6);
		wr(`QPWM_IDX_ENABLE, 8'h00);
		wr(`QPWM_IDX_CONTROL, 8'h00);
		wr(`QPWM_IDX_SCALE_LO, 8'h01);
		wr(`QPWM_IDX_SCALE_UP, 8'h02);
		wr(`QPWM_IDX_SELPOL, 8'hA0);
		wr(`QPWM_IDX_ENABLE, 8'h0A);
		expect_period("scaled lower", 1, 16);
		expect_period("scaled upper", 3, 24);
		wr(`QPWM_IDX_ENABLE, 8'h00);
		wr(`QPWM_IDX_SELPOL, 8'h00);
	endtask
	task automatic t_pair();
		for (int c = 0; c < 4; c += 2) begin
			wr(`QPWM_IDX_CLKPAIR, c == 0 ? 8'h40 : 8'h80);
			wr({`QPWM_GRP_PER, c[1:0]}, 8'h01);
			wr({`QPWM_GRP_PER, c[1:0] + 2'd1}, 8'h00);
			wr({`QPWM_GRP_DTY, c[1:0]}, 8'h00);
			wr({`QPWM_GRP_DTY, c[1:0] + 2'd1}, 8'h80);
			wr({`QPWM_GRP_CNT, c[1:0]}, 8'h00);
			wr(`QPWM_IDX_ENABLE, 8'h01 << c);
			expect_period("pair", c, 257);
			check("pair pins", pin_oe, 4'h1 << c);
			wr(`QPWM_IDX_ENABLE, 8'h00);
		end
		wr(`QPWM_IDX_CLKPAIR, 8'h00);
	endtask
	task automatic t_buffer();
		wr({`QPWM_GRP_PER, 2'd0}, 8'hC8);
		wr({`QPWM_GRP_DTY, 2'd0}, 8'hFF);
		wr(`QPWM_IDX_ENABLE, 8'h01);
		wr({`QPWM_GRP_CNT, 2'd0}, 8'h00);
		xfer({`QPWM_GRP_CNT, 2'd0}, 1'b0, 8'h00);
		check("count read", q < 8'h10, 1'b1);
		wr({`QPWM_GRP_DTY, 2'd0}, 8'h00);
		repeat (20) @(posedge clock);
		check("buffered duty", pin_out[0], 1'b0);
		wr({`QPWM_GRP_CNT, 2'd0}, 8'h00);
		repeat (5) @(posedge clock);
		check("forced duty", pin_out[0], 1'b1);
		wr(`QPWM_IDX_ENABLE, 8'h00);
		wr({`QPWM_GRP_DTY, 2'd0}, 8'hFF);
		wr(`QPWM_IDX_ENABLE, 8'h01);
		repeat (5) @(posedge clock);
		check("direct latch", pin_out[0], 1'b0);
	endtask
	// hang guard, well past the expected run length
	initial begin
		#400000;
		num_errors++;
		wrap_up();
	end
	initial begin
		repeat (8) @(posedge clock);
		nrst <= 1'b1;
		@(posedge clock);
		t_regs();
		t_pins();
		t_polarity();
		t_clocks();
		t_pair();
		t_buffer();
		wrap_up();
	end
endmodule
